// file: rtl/llu_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants for the lighting link unit.
// Assumes: 8-bit registers on a 32-bit classic Wishbone bus.
// Notes:   Printed offsets are register indices; byte address is index * 4.
//////////////////////////////////////////////////////////////////////////////
package llu_pkg;

  localparam int unsigned ADDR_W = 10;

  // Register indices.
  localparam logic [7:0] IDX_RATE_DIVIDER     = 8'h40;
  localparam logic [7:0] IDX_FORWARD_ADDRESS  = 8'h41;
  localparam logic [7:0] IDX_FORWARD_PAYLOAD  = 8'h42;
  localparam logic [7:0] IDX_BACKWARD_PAYLOAD = 8'h43;
  localparam logic [7:0] IDX_LINK_CONTROL     = 8'h44;
  localparam logic [7:0] IDX_LINK_CTRL_STATUS = 8'h45;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Control register fields.
  localparam int unsigned CR_LINK_ENABLE     = 3;
  localparam int unsigned CR_FRAME_ACK       = 2;
  localparam int unsigned CR_DIRECTION       = 1;
  localparam int unsigned CR_FORCED_TRANSMIT = 0;

  // Status register fields.
  localparam int unsigned SR_IRQ_ENABLE = 7;
  localparam int unsigned SR_EOF_FLAG   = 6;
  localparam int unsigned SR_ERROR_FLAG = 5;
  localparam int unsigned SR_DIRECTION  = 4;

  // Sampling: 16 samples per phase, majority of samples 6, 7 and 8, shift at 9.
  localparam logic [3:0] SAMPLE_LAST  = 4'hF;
  localparam logic [3:0] SAMPLE_MAJ_A = 4'h6;
  localparam logic [3:0] SAMPLE_MAJ_B = 4'h7;
  localparam logic [3:0] SAMPLE_MAJ_C = 4'h8;
  localparam logic [3:0] SAMPLE_SHIFT = 4'h9;

  // Two bit periods are four phases of 16 samples.
  localparam logic [6:0] FAIL_SAMPLES = 7'h40;

  // Forward frame: start bit plus 16 data bits; backward: start plus 8 bits.
  localparam logic [4:0] FWD_BITS   = 5'h11;
  localparam logic [4:0] BWD_BITS   = 5'h09;
  // Idle high phases that end a frame: two stop bits.
  localparam logic [2:0] STOP_PHASES = 3'h4;

  typedef enum logic [1:0] {LLU_IDLE, LLU_RX, LLU_TX, LLU_WAIT_ACK} llu_state_t;

endpackage : llu_pkg

// file: rtl/llu_sample_tick.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Sample clock enable at clk / (N+1), sixteen per phase.
// Assumes: Divider value may change at any time; the count restarts only when it is at or above the new value.
// Notes:   One pulse per (N+1) clock cycles.
//////////////////////////////////////////////////////////////////////////////
module llu_sample_tick
  import llu_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] divider_i,
  output logic            tick_o
);

  logic [7:0] count_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || count_reg >= divider_i)
      count_reg <= REG_RESET;
    else
      count_reg <= count_reg + 8'h01;
  end

  assign tick_o = (count_reg >= divider_i);

endmodule // llu_sample_tick

// file: rtl/llu_input_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-stage synchroniser for the serial input pin.
// Assumes: Line idles high.
// Notes:   Only the second stage is visible outside.
//////////////////////////////////////////////////////////////////////////////
module llu_input_sync
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      sync_o
);

  logic meta_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= 1'b1;
      sync_o   <= 1'b1;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // llu_input_sync

// file: rtl/llu_link.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Lighting link unit: bi-phase receive/transmit with register file.
// Assumes: Classic Wishbone slave, 100 MHz clk_i, synchronous reset.
// Notes:   Answers every access with ack one cycle after the request.
//
// What this block does
// - Control bits 7:4 read zero, ignore writes.
// - Enable gates link; changing it resets FSM.
// - Acknowledge bit self-clears; zero after reset.
// - Direction bit: 0 receive, 1 transmit.
// - Forced transmit sends without forward frame.
// - Interrupt enable bit writable, reset zero.
// - Only status bit 7 is writable.
// - End-of-frame flag set after rx/tx frame.
// - Acknowledge clears the end-of-frame flag.
// - Error flag on bad format or failure.
// - Reading status clears the error flag.
// - Direction status: 1 receive, 0 transmit.
// - Status 3:0 captures counter on edges.
// - Sample rate is clk over N+1, sixteen samples per phase.
// - Majority of samples 6,7,8; edge clears counter.
// - Low two bit periods in receive: error.
// - Good forward frame loads address and payload.
//////////////////////////////////////////////////////////////////////////////
//
// The implementer's own choice: the Wishbone register port.
module llu_link
  import llu_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [llu_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    link_rx_i,
  output logic                         link_tx_o,
  output logic                         irq_o
);
  import llu_pkg::*;

  function automatic logic majority3(input logic a, input logic b, input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic       req;
  logic       wr;
  logic       rd;
  logic [7:0] idx;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i && wb_sel_i[0];
  assign rd  = req && !wb_we_i;
  assign idx = wb_adr_i[ADDR_W-1:2];

  logic [7:0] rate_divider_reg;
  logic [7:0] forward_address_reg;
  logic [7:0] forward_payload_reg;
  logic [7:0] backward_payload_reg;
  logic       link_enable_reg;
  logic       frame_ack_reg;
  logic       direction_reg;
  logic       forced_transmit_reg;
  logic       irq_enable_reg;
  logic       eof_flag_reg;
  logic       error_flag_reg;
  logic [3:0] captured_count_reg;
  llu_state_t state_reg;

  logic       wr_ctrl;
  logic       fsm_restart;
  logic       set_eof;
  logic       set_error;
  logic       load_forward;
  logic [15:0] rx_shift_reg;

  assign wr_ctrl     = wr && idx == IDX_LINK_CONTROL;
  // Only a write that changes the enable bit re-arms the state machine; a plain
  // acknowledge must not, or the reply that it releases would be lost.
  assign fsm_restart = wr_ctrl && (wb_dat_i[CR_LINK_ENABLE] != link_enable_reg);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rate_divider_reg     <= REG_RESET;
      backward_payload_reg <= REG_RESET;
      irq_enable_reg       <= 1'b0;
    end
    else if (wr)
    begin
      if (idx == IDX_RATE_DIVIDER)
        rate_divider_reg <= wb_dat_i[7:0];
      if (idx == IDX_BACKWARD_PAYLOAD)
        backward_payload_reg <= wb_dat_i[7:0];
      if (idx == IDX_LINK_CTRL_STATUS)
        irq_enable_reg <= wb_dat_i[SR_IRQ_ENABLE];
    end
  end

  // Control register; the upper nibble is never stored.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      link_enable_reg     <= 1'b0;
      direction_reg       <= 1'b0;
      forced_transmit_reg <= 1'b0;
      frame_ack_reg       <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      link_enable_reg     <= wb_dat_i[CR_LINK_ENABLE];
      direction_reg       <= wb_dat_i[CR_DIRECTION];
      forced_transmit_reg <= wb_dat_i[CR_FORCED_TRANSMIT];
      frame_ack_reg       <= wb_dat_i[CR_FRAME_ACK];
    end
    else
      frame_ack_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
      case (idx)
        IDX_RATE_DIVIDER:     wb_dat_o <= {24'h000000, rate_divider_reg};
        IDX_FORWARD_ADDRESS:  wb_dat_o <= {24'h000000, forward_address_reg};
        IDX_FORWARD_PAYLOAD:  wb_dat_o <= {24'h000000, forward_payload_reg};
        IDX_BACKWARD_PAYLOAD: wb_dat_o <= {24'h000000, backward_payload_reg};
        IDX_LINK_CONTROL:     wb_dat_o <= {28'h0000000, link_enable_reg, frame_ack_reg,
                                           direction_reg, forced_transmit_reg};
        IDX_LINK_CTRL_STATUS: wb_dat_o <= {24'h000000, irq_enable_reg, eof_flag_reg, error_flag_reg,
                                           state_reg != LLU_TX, captured_count_reg};
        default:              wb_dat_o <= 32'h0000_0000;
      endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flags. A set in the same cycle as a clear wins.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      eof_flag_reg <= 1'b0;
    else if (set_eof)
      eof_flag_reg <= 1'b1;
    else if (wr_ctrl && wb_dat_i[CR_FRAME_ACK])
      eof_flag_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      error_flag_reg <= 1'b0;
    else if (set_error)
      error_flag_reg <= 1'b1;
    else if (rd && idx == IDX_LINK_CTRL_STATUS)
      error_flag_reg <= 1'b0;
  end

  assign irq_o = irq_enable_reg & eof_flag_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      forward_address_reg <= REG_RESET;
      forward_payload_reg <= REG_RESET;
    end
    else if (load_forward)
    begin
      forward_address_reg <= rx_shift_reg[15:8];
      forward_payload_reg <= rx_shift_reg[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sampling of the line.

  logic tick;
  logic line;

  llu_sample_tick u_tick
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .divider_i (rate_divider_reg),
    .tick_o    (tick)
  );

  llu_input_sync u_sync
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (link_rx_i),
    .sync_o (line)
  );

  logic       line_prev_reg;
  logic [3:0] sample_cnt_reg;
  logic [2:0] maj_reg;
  logic       edge_seen;
  logic       phase_level;
  logic [6:0] low_cnt_reg;

  assign edge_seen   = tick && (line != line_prev_reg);
  assign phase_level = majority3(maj_reg[0], maj_reg[1], maj_reg[2]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      line_prev_reg      <= 1'b1;
      sample_cnt_reg     <= 4'h0;
      captured_count_reg <= 4'h0;
      maj_reg            <= 3'h7;
    end
    else if (tick)
    begin
      line_prev_reg <= line;
      if (edge_seen)
      begin
        captured_count_reg <= sample_cnt_reg;
        sample_cnt_reg     <= 4'h0;
      end
      else
        sample_cnt_reg <= sample_cnt_reg + 4'h1;
      if (sample_cnt_reg == SAMPLE_MAJ_A)
        maj_reg[0] <= line;
      if (sample_cnt_reg == SAMPLE_MAJ_B)
        maj_reg[1] <= line;
      if (sample_cnt_reg == SAMPLE_MAJ_C)
        maj_reg[2] <= line;
    end
  end

  // Line failure counter runs in every state except transmit.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || line || state_reg == LLU_TX)
      low_cnt_reg <= 7'h00;
    else if (tick && low_cnt_reg != FAIL_SAMPLES)
      low_cnt_reg <= low_cnt_reg + 7'h01;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame state machine.

  logic [1:0] pre_reg;
  logic [4:0] bit_cnt_reg;
  logic       phase_reg;
  logic [2:0] idle_cnt_reg;
  logic [8:0] tx_shift_reg;
  logic       tx_line_reg;
  logic       phase_end;
  logic       rx_strobe;
  logic       fail_hit;

  // In transmit the sample counter never sees line edges from us, so a phase
  // ends on the counter's own wrap.
  assign phase_end = tick && sample_cnt_reg == SAMPLE_LAST;
  assign rx_strobe = tick && sample_cnt_reg == SAMPLE_SHIFT;
  assign fail_hit  = tick && low_cnt_reg == FAIL_SAMPLES - 7'h01 && state_reg != LLU_TX;

  always_ff @(posedge clk_i)
  begin
    set_eof      <= 1'b0;
    set_error    <= 1'b0;
    load_forward <= 1'b0;
    if (rst_i || fsm_restart || !link_enable_reg)
    begin
      state_reg    <= LLU_IDLE;
      phase_reg    <= 1'b0;
      bit_cnt_reg  <= 5'h00;
      pre_reg      <= 2'h0;
      idle_cnt_reg <= 3'h0;
      rx_shift_reg <= 16'h0000;
      tx_shift_reg <= 9'h000;
      tx_line_reg  <= 1'b1;
      // A freshly enabled link starts at once when forced.
      if (!rst_i && fsm_restart && wb_dat_i[CR_LINK_ENABLE] && wb_dat_i[CR_FORCED_TRANSMIT])
      begin
        state_reg    <= LLU_TX;
        tx_shift_reg <= {1'b1, backward_payload_reg};
      end
    end
    else
    begin
      if (fail_hit)
      begin
        set_error <= 1'b1;
        state_reg <= LLU_IDLE;
      end
      else
        case (state_reg)
          LLU_IDLE:
            if (forced_transmit_reg)
            begin
              state_reg    <= LLU_TX;
              tx_shift_reg <= {1'b1, backward_payload_reg};
              phase_reg    <= 1'b0;
              bit_cnt_reg  <= 5'h00;
              idle_cnt_reg <= 3'h0;
            end
            else if (rx_strobe && !phase_level)
            begin
              // First phase of the start bit is low; the pre-shifter forgets the last frame.
              state_reg   <= LLU_RX;
              phase_reg   <= 1'b1;
              bit_cnt_reg <= 5'h00;
              pre_reg     <= 2'h0;
            end
          LLU_RX:
            if (rx_strobe)
            begin
              pre_reg   <= {pre_reg[0], phase_level};
              phase_reg <= !phase_reg;
              if (phase_reg)
              begin
                if (pre_reg[0] == phase_level)
                begin
                  // A bit without mid-phase transition is a format error unless it is the stop idle.
                  state_reg <= LLU_IDLE;
                  if (!(phase_level && bit_cnt_reg == FWD_BITS))
                    set_error <= 1'b1;
                  else
                  begin
                    load_forward <= 1'b1;
                    set_eof      <= 1'b1;
                    state_reg    <= LLU_WAIT_ACK;
                  end
                end
                else
                begin
                  bit_cnt_reg  <= bit_cnt_reg + 5'h01;
                  rx_shift_reg <= {rx_shift_reg[14:0], phase_level};
                end
              end
            end
          LLU_TX:
            if (phase_end)
            begin
              phase_reg <= !phase_reg;
              if (bit_cnt_reg == BWD_BITS)
              begin
                tx_line_reg  <= 1'b1;
                idle_cnt_reg <= idle_cnt_reg + 3'h1;
                if (idle_cnt_reg == STOP_PHASES)
                begin
                  set_eof   <= 1'b1;
                  state_reg <= LLU_WAIT_ACK;
                end
              end
              else if (!phase_reg)
                tx_line_reg <= !tx_shift_reg[8];
              else
              begin
                tx_line_reg  <= tx_shift_reg[8];
                tx_shift_reg <= {tx_shift_reg[7:0], 1'b0};
                bit_cnt_reg  <= bit_cnt_reg + 5'h01;
              end
            end
          LLU_WAIT_ACK:
            ;
          default:
            state_reg <= LLU_IDLE;
        endcase
      // Acknowledge releases the next transfer in the chosen direction.
      if (frame_ack_reg && state_reg == LLU_WAIT_ACK)
      begin
        phase_reg    <= 1'b0;
        bit_cnt_reg  <= 5'h00;
        idle_cnt_reg <= 3'h0;
        if (direction_reg || forced_transmit_reg)
        begin
          state_reg    <= LLU_TX;
          tx_shift_reg <= {1'b1, backward_payload_reg};
        end
        else
          state_reg <= LLU_IDLE;
      end
    end
  end

  assign link_tx_o = tx_line_reg;

endmodule // llu_link

// file: testbench/llu_link_asserts.sv
////////////////////////////////////////
// Purpose: Port-level checks of the lighting link unit.
// Assumes: Register index is the byte address divided by four.
// Notes:   Shadows follow enable and irq enable from acknowledged writes.
////////////////////////////////////////
module llu_link_asserts
  import llu_pkg::*;
(
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [llu_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic                       link_rx_i,
  input wire logic                       link_tx_o,
  input wire logic                       irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] idx;
  logic       ite_sh;
  logic       en_sh;
  assign idx = wb_adr_i[9:2];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ite_sh <= 1'b0;
      en_sh  <= 1'b0;
    end
    else if (wb_ack_o && wb_we_i && wb_sel_i[0])
    begin
      if (idx == IDX_LINK_CTRL_STATUS)
        ite_sh <= wb_dat_i[SR_IRQ_ENABLE];
      if (idx == IDX_LINK_CONTROL)
        en_sh <= wb_dat_i[CR_LINK_ENABLE];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] i);
    wb_ack_o && !wb_we_i && idx == i;
  endsequence
  sequence s_ack_wr;
    s_req ##0 wb_we_i && wb_sel_i[0] && idx == IDX_LINK_CONTROL && wb_dat_i[CR_FRAME_ACK];
  endsequence
  // Shadows lag the bus by one cycle, so idle bus cycles are required.
  a_ack_follows: assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_dat_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000) else $error("upper data set");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && (idx < IDX_RATE_DIVIDER || idx > IDX_LINK_CTRL_STATUS)
    |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
  a_ctrl_hi_zero: assert property (s_rd(IDX_LINK_CONTROL) |-> wb_dat_o[7:4] == 4'h0) else $error("control high set");
  a_ack_bit_clear: assert property (s_rd(IDX_LINK_CONTROL) |-> !wb_dat_o[CR_FRAME_ACK]) else $error("ack bit stuck");
  a_irq_masked: assert property (!ite_sh && !$past(ite_sh) && !wb_cyc_i |-> !irq_o) else $error("irq while masked");
  a_irq_is_and: assert property (s_rd(IDX_LINK_CTRL_STATUS) |-> irq_o == (wb_dat_o[7] && wb_dat_o[6]))
    else $error("irq not enable and flag");
  a_eof_ack_clr: assert property (s_ack_wr |-> ##[1:3] !irq_o) else $error("flag kept after acknowledge");
  a_tx_phase_hold: assert property ($changed(link_tx_o) |=> $stable(link_tx_o) [*8])
    else $error("tx phase too short");
  a_tx_idle_off: assert property (!en_sh && !$past(en_sh) && !wb_cyc_i |-> link_tx_o)
    else $error("tx active while disabled");
endmodule // llu_link_asserts
////////////////////////////////////////
bind llu_link llu_link_asserts u_llu_link_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .link_rx_i(link_rx_i), .link_tx_o(link_tx_o), .irq_o(irq_o));

// file: testbench/llu_fwd_sender.sv
////////////////////////////////////////
// Purpose: Bus controller model that sends bi-phase forward frames.
// Assumes: First phase of each bit is its inverse; line has a pull-up.
// Notes:   fail_i pulls the line low to mimic a broken interface.
////////////////////////////////////////
module llu_fwd_sender
#(
  parameter int PHASE_CLKS = 32
)
(
  input  wire logic        clk_i,
  input  wire logic        send_i,
  input  wire logic [15:0] frame_i,
  input  wire logic        fail_i,
  output logic             line_o,
  output logic             busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [16:0] bits;
  logic        drive = 1'b1;
  logic        busy  = 1'b0;
  assign line_o = drive && !fail_i;
  assign busy_o = busy;
  always @(posedge clk_i)
  begin
    if (send_i && !busy)
    begin
      busy <= 1'b1;
      bits = {1'b1, frame_i};
      for (int i = 16; i >= 0; i--)
      begin
        drive <= ~bits[i];
        repeat (PHASE_CLKS) @(posedge clk_i);
        drive <= bits[i];
        repeat (PHASE_CLKS) @(posedge clk_i);
      end
      // Released line returns high through the pull-up for two stop bits.
      drive <= 1'b1;
      repeat (4 * PHASE_CLKS) @(posedge clk_i);
      busy <= 1'b0;
    end
  end
endmodule // llu_fwd_sender

// file: testbench/llu_link_bench.sv
////////////////////////////////////////
// Purpose: Register and link tests of the lighting link unit.
// Assumes: Divider 1, so one phase lasts 32 clocks.
// Notes:   Reads are masked where the sample count is not fixed.
////////////////////////////////////////
module llu_link_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import llu_pkg::*;
  localparam int PH = 32;
  logic                clk_i;
  logic                rst_i;
  logic                wb_cyc;
  logic                wb_stb;
  logic                wb_we;
  logic [ADDR_W-1:0]   wb_adr;
  logic [3:0]          wb_sel;
  logic [31:0]         wb_dat;
  logic [31:0]         wb_rdat;
  logic                wb_ack;
  logic                line;
  logic                link_tx;
  logic                irq;
  logic                fwd_send;
  logic                fwd_fail;
  logic [15:0]         fwd_frame;
  logic                fwd_busy;
  logic [7:0]          q;
  logic [7:0]          sec;
  logic [7:0]          fst;
  logic [17:0]         ph;
  int                  num_errors = 0;
  int                  compares = 0;
  llu_link u_llu_link (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .link_rx_i(line), .link_tx_o(link_tx), .irq_o(irq));
  llu_fwd_sender #(.PHASE_CLKS(PH)) u_llu_fwd_sender (.clk_i(clk_i), .send_i(fwd_send), .frame_i(fwd_frame),
    .fail_i(fwd_fail), .line_o(line), .busy_o(fwd_busy));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic timeout(input string what);
    num_errors++;
    $display("CHECK FAILED %s expected response seen timeout", what);
    results();
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb_xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= {i, 2'b00};
    wb_dat <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1)
      timeout("bus ack");
  endtask
  task automatic rd_chk(input string what, input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
    wb_xfer(1'b0, i, 8'h00);
    check8(what, e, q & m);
  endtask
  task automatic wait_for(input int which, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (n < lim && (which == 0 ? fwd_busy !== 1'b0 : which == 1 ? link_tx !== 1'b0 : irq !== 1'b1));
    if (n >= lim)
      timeout("link event");
  endtask
  task automatic send_frame(input logic [15:0] f);
    @(posedge clk_i);
    fwd_frame <= f;
    fwd_send  <= 1'b1;
    @(posedge clk_i);
    fwd_send <= 1'b0;
    wait_for(0, 3000);
    repeat (8) @(posedge clk_i);
  endtask
  ////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = '0;
    wb_sel = 4'hF;
    wb_dat = 32'h00000000;
    fwd_send = 1'b0;
    fwd_fail = 1'b0;
    fwd_frame = 16'h0000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    check8("tx idle", 8'h01, {7'h00, link_tx});
    for (int i = 0; i < 5; i++)
      rd_chk("reset value", IDX_RATE_DIVIDER + 8'(i), 8'hFF, 8'h00);
    rd_chk("status reset", IDX_LINK_CTRL_STATUS, 8'hF0, 8'h10);
    $display("test reset done");
    wb_xfer(1'b1, IDX_RATE_DIVIDER, 8'h01);
    rd_chk("rate_divider", IDX_RATE_DIVIDER, 8'hFF, 8'h01);
    wb_xfer(1'b1, IDX_BACKWARD_PAYLOAD, 8'hA5);
    rd_chk("backward_payload", IDX_BACKWARD_PAYLOAD, 8'hFF, 8'hA5);
    wb_xfer(1'b1, IDX_FORWARD_ADDRESS, 8'hFF);
    rd_chk("forward_address", IDX_FORWARD_ADDRESS, 8'hFF, 8'h00);
    wb_xfer(1'b1, 8'h46, 8'hFF);
    rd_chk("unmapped", 8'h46, 8'hFF, 8'h00);
    wb_xfer(1'b1, IDX_LINK_CONTROL, 8'hF2);
    rd_chk("link_control", IDX_LINK_CONTROL, 8'hFF, 8'h02);
    wb_xfer(1'b1, IDX_LINK_CONTROL, 8'h00);
    wb_xfer(1'b1, IDX_LINK_CTRL_STATUS, 8'hFF);
    rd_chk("status write", IDX_LINK_CTRL_STATUS, 8'hFF, 8'h90);
    $display("test registers done");
    send_frame(16'h1234);
    rd_chk("address disabled", IDX_FORWARD_ADDRESS, 8'hFF, 8'h00);
    rd_chk("flag disabled", IDX_LINK_CTRL_STATUS, 8'h40, 8'h00);
    wb_xfer(1'b1, IDX_LINK_CONTROL, 8'h08);
    send_frame(16'h3C5A);
    rd_chk("forward_address", IDX_FORWARD_ADDRESS, 8'hFF, 8'h3C);
    rd_chk("forward_payload", IDX_FORWARD_PAYLOAD, 8'hFF, 8'h5A);
    check8("irq frame", 8'h01, {7'h00, irq});
    rd_chk("status frame", IDX_LINK_CTRL_STATUS, 8'hFF, 8'hDF);
    send_frame(16'h0102);
    rd_chk("address held", IDX_FORWARD_ADDRESS, 8'hFF, 8'h3C);
    wb_xfer(1'b1, IDX_LINK_CONTROL, 8'h0C);
    check8("irq acknowledged", 8'h00, {7'h00, irq});
    rd_chk("ack self clear", IDX_LINK_CONTROL, 8'hFF, 8'h08);
    send_frame(16'h00FF);
    rd_chk("second payload", IDX_FORWARD_PAYLOAD, 8'hFF, 8'hFF);
    wb_xfer(1'b1, IDX_LINK_CONTROL, 8'h0E);
    wait_for(1, 200);
    rd_chk("status replying", IDX_LINK_CTRL_STATUS, 8'h50, 8'h00);
    wait_for(2, 1400);
    wb_xfer(1'b1, IDX_LINK_CONTROL, 8'h0C);
    $display("test receive done");
    wb_xfer(1'b1, IDX_LINK_CONTROL, 8'h00);
    wb_xfer(1'b1, IDX_LINK_CONTROL, 8'h09);
    wait_for(1, 200);
    for (int k = 17; k >= 0; k--)
    begin
      repeat (k == 17 ? PH / 2 : PH) @(posedge clk_i);
      ph[k] = link_tx;
    end
    for (int j = 0; j < 8; j++)
    begin
      sec[7 - j] = ph[14 - 2 * j];
      fst[7 - j] = ph[15 - 2 * j];
    end
    check8("start bit", 8'h01, {6'h00, ph[17], ph[16]});
    check8("tx data", 8'hA5, sec);
    check8("tx first phases", 8'h5A, fst);
    rd_chk("status sending", IDX_LINK_CTRL_STATUS, 8'h50, 8'h00);
    wait_for(2, 400);
    rd_chk("status sent", IDX_LINK_CTRL_STATUS, 8'hF0, 8'hD0);
    wb_xfer(1'b1, IDX_LINK_CTRL_STATUS, 8'h00);
    check8("irq masked", 8'h00, {7'h00, irq});
    rd_chk("flag kept", IDX_LINK_CTRL_STATUS, 8'hF0, 8'h50);
    wb_xfer(1'b1, IDX_LINK_CONTROL, 8'h0C);
    rd_chk("flag cleared", IDX_LINK_CTRL_STATUS, 8'h40, 8'h00);
    $display("test transmit done");
    @(posedge clk_i);
    fwd_fail <= 1'b1;
    repeat (200) @(posedge clk_i);
    fwd_fail <= 1'b0;
    repeat (40) @(posedge clk_i);
    rd_chk("error set", IDX_LINK_CTRL_STATUS, 8'h20, 8'h20);
    rd_chk("error cleared", IDX_LINK_CTRL_STATUS, 8'h20, 8'h00);
    $display("test failure done");
    results();
  end
endmodule // llu_link_bench
